// *** cpu_side_model.sv ***
`timescale 1ns/1ps
module cpu_side_model (
  // command and device reset
  input  logic hold_in,
  input  logic cpu_reset_n_in,
  // watchdog line and restart count
  output logic guard_timer_signal_out,
  output int   restarts_out
);
  // a processor in reset no longer holds the line
  assign guard_timer_signal_out = hold_in && cpu_reset_n_in;
  initial restarts_out = 0;
  always @(negedge cpu_reset_n_in) restarts_out <= restarts_out + 1;
endmodule : cpu_side_model

// *** fault_latch_pkg.sv ***
package fault_latch_pkg;

  // ----------------------------------------
  // register map (apb byte addresses)
  // ----------------------------------------
  localparam logic [7:0]  CTRL_ADDR     = 8'h00;
  localparam logic [7:0]  STATUS_ADDR   = 8'h04;
  localparam logic [7:0]  GATE_ADDR     = 8'h08;
  localparam logic [7:0]  KICK_ADDR     = 8'h0C;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_CLEAR_BIT   = 0;
  localparam int CTRL_BOOT_BIT    = 1;
  localparam int ST_STICKY_BIT    = 0;
  localparam int ST_LIVE_BIT      = 1;
  localparam int ST_SHORT_BIT     = 2;
  localparam int ST_DCOC_BIT      = 3;
  localparam int ST_OV_BIT        = 4;
  localparam int ST_WDRST_BIT     = 5;
  localparam int ST_BOOT_BIT      = 6;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [5:0]  GATE_RESET    = 6'h00;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int  CLK_MHZ          = 200;
  localparam real WD_TIMEOUT_MIN_S = 0.9;
  localparam real WD_TIMEOUT_TYP_S = 1.6;
  localparam real WD_TIMEOUT_MAX_S = 2.5;
  localparam longint WD_TIMEOUT_CYCLES = longint'(WD_TIMEOUT_TYP_S * CLK_MHZ * 1.0e6);
  localparam int  SC_DELAY_TYP_US  = 3;
  localparam int  SC_DELAY_MAX_US  = 6;
  localparam int  SC_DELAY_MAX_CYCLES = SC_DELAY_MAX_US * CLK_MHZ;
  localparam int  SYNC_STAGES      = 2;
  localparam int  RST_PULSE_CYCLES = 16;

endpackage : fault_latch_pkg

// *** fault_latch_sva.sv ***
`timescale 1ns/1ps
module fault_latch_sva (
  // clock, reset, apb
  input logic        core_clk_in,
  input logic        nrst_in,
  input logic        clk_en_in,
  input logic        psel_in,
  input logic        penable_in,
  input logic        pwrite_in,
  input logic [7:0]  paddr_in,
  input logic [31:0] pwdata_in,
  input logic        pready_out,
  // detectors, watchdog line, trip and reset outputs
  input logic [2:0]  phase_short_in,
  input logic        dc_minus_oc_in,
  input logic        dc_overvolt_in,
  input logic        guard_timer_signal_in,
  input logic        sticky_trip_flag_out,
  input logic        protect_irq_a_n_out,
  input logic        protect_irq_b_n_out,
  input logic        cpu_reset_n_out
);
  import fault_latch_pkg::*;
  // ----------------
  // trip and reset checks
  // ----------------
  wire flt = |phase_short_in | dc_minus_oc_in | dc_overvolt_in;
  wire nflt = !flt;
  wire stk = sticky_trip_flag_out;
  wire irq = protect_irq_a_n_out;
  wire rsn = cpu_reset_n_out;
  wire clr = psel_in && penable_in && pready_out && pwrite_in && paddr_in == CTRL_ADDR
             && pwdata_in[CTRL_CLEAR_BIT];
  default clocking @(posedge core_clk_in); endclocking
  // a frozen core makes no progress, so every count stalls with it
  default disable iff (!nrst_in || !clk_en_in);
  a_sticky_set: assert property (flt [*3] |=> stk)
    else $error("sticky not set");
  a_sticky_hold: assert property (stk && !clr |=> stk)
    else $error("sticky dropped");
  // set wins, so only a fault-free pipeline may clear
  a_sticky_clear: assert property (clr && nflt && $past(nflt) && $past(nflt, 2) |=> !stk)
    else $error("sticky not cleared");
  a_live_low: assert property (flt [*3] |=> !irq)
    else $error("live trip missing");
  a_live_off: assert property (nflt [*3] |=> irq)
    else $error("live trip stuck");
  a_irqb_idle: assert property (protect_irq_b_n_out)
    else $error("second input active");
  a_rst_pulse: assert property ($fell(rsn) |-> ##15 !rsn ##1 rsn)
    else $error("reset pulse length");
  a_rst_cause: assert property ($fell(rsn) |-> $past(guard_timer_signal_in))
    else $error("reset without hold");
  c_clear: cover property (clr);
  c_trip: cover property (flt ##1 nflt);
  c_reset: cover property ($fell(rsn));
endmodule : fault_latch_sva
bind inverter_fault_latch fault_latch_sva fault_latch_sva_i (.*);

// *** inverter_fault_latch.sv ***
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
module inverter_fault_latch
  import fault_latch_pkg::*;
#(
  parameter longint WD_CYCLES = WD_TIMEOUT_CYCLES
) (
  // clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        clk_en_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // fault detectors (active high, asynchronous)
  input  wire logic [2:0]  phase_short_in,
  input  wire logic        dc_minus_oc_in,
  input  wire logic        dc_overvolt_in,
  // watchdog and boot strap
  input  wire logic        guard_timer_signal_in,
  input  wire logic        boot_en_n_in,
  // fault, reset and boot outputs
  output logic             sticky_trip_flag_out,
  output logic             protect_irq_a_n_out,
  output logic             protect_irq_b_n_out,
  output logic             cpu_reset_n_out,
  output logic             boot_rom_sel_out,
  // gate drives
  output logic             gate_out1_high_out,
  output logic             gate_out1_low_out,
  output logic             gate_out2_high_out,
  output logic             gate_out2_low_out,
  output logic             gate_out3_high_out,
  output logic             gate_out3_low_out
);
  import fault_latch_pkg::*;

  // core_clk_in is the pll output from the reference oscillator

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic       wd_s1_q;
  logic       wd_s2_q;
  wire  [4:0] raw_faults = {dc_overvolt_in, dc_minus_oc_in, phase_short_in};

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      wd_s1_q <= 1'b0;
      wd_s2_q <= 1'b0;
    end else if (clk_en_in) begin
      sync1_q <= raw_faults;
      sync2_q <= sync1_q;
      wd_s1_q <= guard_timer_signal_in;
      wd_s2_q <= wd_s1_q;
    end
  end

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire        acc     = psel_in && penable_in;
  wire        wr_acc  = acc && pwrite_in;
  wire        hit_ctl = paddr_in == CTRL_ADDR;
  wire        hit_st  = paddr_in == STATUS_ADDR;
  wire        hit_gt  = paddr_in == GATE_ADDR;
  wire        hit_kk  = paddr_in == KICK_ADDR;
  wire        mapped  = hit_ctl || hit_st || hit_gt || hit_kk;
  wire        clr_wr  = wr_acc && hit_ctl && pwdata_in[CTRL_CLEAR_BIT];
  wire        any_flt = |sync2_q;

  // ----------------------------------------
  // fault latch
  // ----------------------------------------
  logic       sticky_q;
  logic       live_n_q;
  logic [4:0] cause_q;
  // set wins over clear so a fault in the clearing cycle is kept
  wire        sticky_d = any_flt | (sticky_q & ~clr_wr);
  wire  [4:0] cause_d  = sync2_q | (cause_q & {5{~clr_wr}});

  // powers up set, so software must clear once after boot
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      sticky_q <= 1'b1;
      live_n_q <= 1'b1;
      cause_q  <= 5'h00;
    end else if (clk_en_in) begin
      sticky_q <= sticky_d;
      live_n_q <= ~any_flt;
      cause_q  <= cause_d;
    end
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  logic [31:0] wd_cnt_q;
  logic [4:0]  rst_cnt_q;
  logic        cpu_rst_n_q;
  logic        wd_fired_q;
  wire         wd_kick = wr_acc && hit_kk;
  wire         wd_exp  = wd_s2_q && (wd_cnt_q >= 32'(WD_CYCLES - 1));

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      wd_cnt_q    <= 32'h0000_0000;
      rst_cnt_q   <= 5'h00;
      cpu_rst_n_q <= 1'b1;
      wd_fired_q  <= 1'b0;
    end else if (clk_en_in) begin
      if (!wd_s2_q || wd_kick || wd_exp) begin
        wd_cnt_q <= 32'h0000_0000;
      end else begin
        wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
      end
      if (wd_exp) begin
        rst_cnt_q   <= 5'(RST_PULSE_CYCLES);
        cpu_rst_n_q <= 1'b0;
        wd_fired_q  <= 1'b1;
      end else if (rst_cnt_q != 5'h00) begin
        rst_cnt_q   <= rst_cnt_q - 5'h01;
        cpu_rst_n_q <= (rst_cnt_q == 5'h01);
      end
      if (wr_acc && hit_st) begin
        wd_fired_q <= wd_exp;
      end
    end
  end

  // ----------------------------------------
  // boot strap, gate drives
  // ----------------------------------------
  logic       boot_q;
  logic       boot_taken_q;
  logic [5:0] gate_q;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      boot_q       <= 1'b0;
      boot_taken_q <= 1'b0;
      gate_q       <= GATE_RESET;
    end else if (clk_en_in) begin
      if (!boot_taken_q) begin
        boot_q       <= ~boot_en_n_in;
        boot_taken_q <= 1'b1;
      end
      if (wr_acc && hit_gt) begin
        gate_q <= pwdata_in[5:0];
      end
    end
  end

  // ----------------------------------------
  // second protection input
  // ----------------------------------------
  // a flop rather than a tie so every output leaves a register
  logic irq_b_n_q;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      irq_b_n_q <= 1'b1;
    end else if (clk_en_in) begin
      irq_b_n_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire [31:0] st_word = {25'h0, boot_q, wd_fired_q, cause_q[4], cause_q[3],
                         |cause_q[2:0], ~live_n_q, sticky_q};
  wire [31:0] rd_word = hit_st  ? st_word :
                        hit_gt  ? {26'h0, gate_q} :
                        hit_ctl ? {30'h0, boot_q, 1'b0} : RDATA_RESET;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      prdata_out  <= RDATA_RESET;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else if (clk_en_in) begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !mapped;
      prdata_out  <= (psel_in && !penable_in && !pwrite_in) ? rd_word : RDATA_RESET;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sticky_trip_flag_out = sticky_q;
  assign protect_irq_a_n_out  = live_n_q;
  assign protect_irq_b_n_out  = irq_b_n_q;
  assign cpu_reset_n_out      = cpu_rst_n_q;
  assign boot_rom_sel_out     = boot_q;
  // even gate_q bits are high sides
  assign gate_out1_high_out   = gate_q[0];
  assign gate_out1_low_out    = gate_q[1];
  assign gate_out2_high_out   = gate_q[2];
  assign gate_out2_low_out    = gate_q[3];
  assign gate_out3_high_out   = gate_q[4];
  assign gate_out3_low_out    = gate_q[5];

endmodule : inverter_fault_latch

// *** inverter_fault_latch_test.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module inverter_fault_latch_test;
  import fault_latch_pkg::*;
  // ----------------
  // bench wiring
  // ----------------
  localparam longint WD = 50;
  logic core_clk_in = 0, nrst_in = 0, clk_en_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [7:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, rd;
  logic [4:0] flt = 0;
  logic pready_out, pslverr_out, er, boot_en_n_in = 0, hold = 0, boot_rom_sel_out;
  logic sticky_trip_flag_out, protect_irq_a_n_out, protect_irq_b_n_out, cpu_reset_n_out;
  logic gate_out1_high_out, gate_out1_low_out, gate_out2_high_out, gate_out2_low_out;
  logic gate_out3_high_out, gate_out3_low_out, guard_timer_signal_in;
  wire [2:0] phase_short_in = flt[2:0];
  wire dc_minus_oc_in = flt[3];
  wire dc_overvolt_in = flt[4];
  wire [5:0] gates = {gate_out3_low_out, gate_out3_high_out, gate_out2_low_out,
                      gate_out2_high_out, gate_out1_low_out, gate_out1_high_out};
  int n_fail = 0, comparisons = 0, restarts, t;
  always #2.5 core_clk_in = ~core_clk_in;
  inverter_fault_latch #(.WD_CYCLES(WD)) inverter_fault_latch_i (.*);
  cpu_side_model cpu_side_model_i (.hold_in(hold), .cpu_reset_n_in(cpu_reset_n_out),
    .guard_timer_signal_out(guard_timer_signal_in), .restarts_out(restarts));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    @(posedge core_clk_in);
    while (pready_out !== 1'b1) @(posedge core_clk_in);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge core_clk_in);
  endtask : apb
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // tests need well under a thousand cycles; eight thousand is ample margin
  initial begin
    #40us;
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    `CHK("boot_sel", 1'b1, boot_rom_sel_out)
    `CHK("sticky_boot", 1'b1, sticky_trip_flag_out)
    `CHK("irq_b", 1'b1, protect_irq_b_n_out)
    `CHK("gates_rst", 6'h00, gates)
    apb(1'b1, CTRL_ADDR, 32'h0000_0001);
    `CHK("boot_clear", 1'b0, sticky_trip_flag_out)
    apb(1'b0, CTRL_ADDR, 32'h0);
    `CHK("ctrl_boot", 1'b1, rd[CTRL_BOOT_BIT])
    $display("boot test done");
    for (int i = 0; i < 5; i++) begin
      flt <= 5'h01 << i;
      repeat (4) @(posedge core_clk_in);
      `CHK("live", 1'b0, protect_irq_a_n_out)
      `CHK("sticky", 1'b1, sticky_trip_flag_out)
      apb(1'b1, CTRL_ADDR, 32'h0000_0001);
      `CHK("set_wins", 1'b1, sticky_trip_flag_out)
      flt <= 5'h00;
      repeat (4) @(posedge core_clk_in);
      `CHK("live_off", 1'b1, protect_irq_a_n_out)
      `CHK("held", 1'b1, sticky_trip_flag_out)
      apb(1'b0, STATUS_ADDR, 32'h0);
      `CHK("cause", 1'b1, rd[i < 3 ? ST_SHORT_BIT : i])
      `CHK("st_sticky", 1'b1, rd[ST_STICKY_BIT])
      `CHK("st_live", 1'b0, rd[ST_LIVE_BIT])
      apb(1'b1, CTRL_ADDR, 32'h0000_0001);
      `CHK("clear", 1'b0, sticky_trip_flag_out)
    end
    $display("fault test done");
    // enable low: a fault must not reach the latch until the core runs again
    clk_en_in <= 1'b0;
    flt <= 5'h01;
    repeat (6) @(posedge core_clk_in);
    `CHK("frozen", 1'b0, sticky_trip_flag_out)
    `CHK("frozen_live", 1'b1, protect_irq_a_n_out)
    clk_en_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    `CHK("thawed", 1'b1, sticky_trip_flag_out)
    flt <= 5'h00;
    repeat (4) @(posedge core_clk_in);
    apb(1'b1, CTRL_ADDR, 32'h0000_0001);
    `CHK("thaw_clear", 1'b0, sticky_trip_flag_out)
    $display("enable test done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, GATE_ADDR, 32'h1 << i);
      `CHK("gate", 6'h01 << i, gates)
    end
    apb(1'b0, 8'h10, 32'h0);
    `CHK("slverr", 1'b1, er)
    `CHK("unmapped", 32'h0, rd)
    $display("register test done");
    hold <= 1'b1;
    t = 0;
    while (cpu_reset_n_out !== 1'b0) begin
      @(posedge core_clk_in);
      t++;
    end
    hold <= 1'b0;
    `CHK("wd_window", 1'b1, t >= WD && t <= WD + 6)
    t = 0;
    while (cpu_reset_n_out !== 1'b1) begin
      @(posedge core_clk_in);
      t++;
    end
    `CHK("pulse", 16, t)
    `CHK("restarts", 1, restarts)
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHK("wd_flag", 1'b1, rd[ST_WDRST_BIT])
    apb(1'b1, STATUS_ADDR, 32'h0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    `CHK("wd_flag_clr", 1'b0, rd[ST_WDRST_BIT])
    $display("watchdog test done");
    // kicks spaced inside the timeout keep the processor running
    hold <= 1'b1;
    repeat (3) begin
      repeat (40) @(posedge core_clk_in);
      apb(1'b1, KICK_ADDR, 32'h0);
    end
    hold <= 1'b0;
    `CHK("kicked", 1'b1, cpu_reset_n_out)
    `CHK("no_restart", 1, restarts)
    $display("kick test done");
    nrst_in <= 1'b0;
    boot_en_n_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    `CHK("boot_off", 1'b0, boot_rom_sel_out)
    `CHK("sticky_rst", 1'b1, sticky_trip_flag_out)
    apb(1'b1, CTRL_ADDR, 32'h0000_0001);
    `CHK("rst_clear", 1'b0, sticky_trip_flag_out)
    $display("reset test done");
    give_verdict();
  end
endmodule : inverter_fault_latch_test
